// ==== gpib_status_regs.vh ====
`ifndef GPIB_STATUS_REGS_VH
`define GPIB_STATUS_REGS_VH
// Register offsets (word index on the plain port)
`define OFF_RUN_COND 4'h0
`define OFF_RUN_EVENT 4'h1
`define OFF_RUN_MASK 4'h2
`define OFF_RUN_RISE 4'h3
`define OFF_RUN_FALL 4'h4
`define OFF_FLT_COND 4'h5
`define OFF_FLT_EVENT 4'h6
`define OFF_FLT_MASK 4'h7
`define OFF_FLT_RISE 4'h8
`define OFF_FLT_FALL 4'h9
`define OFF_SRE 4'ha
`define OFF_STB 4'hb
`define OFF_PORT 4'hc
`define OFF_ADDR 4'hd
`define OFF_ERROR 4'he
`define OFF_TRIG 4'hf
// Run-state condition bit positions
`define RUN_CAL_BIT 0
`define RUN_WTG_BIT 5
`define RUN_CV_BIT 8
`define RUN_CC_BIT 10
`define RUN_IMPL_MASK 16'h0521
// Fault condition bit positions
`define FLT_OV_BIT 0
`define FLT_OC_BIT 1
`define FLT_IMPL_MASK 16'h0003
// Status byte bit positions
`define STB_ERR_BIT 2
`define STB_FLT_BIT 3
`define STB_RQS_BIT 6
`define STB_RUN_BIT 7
// Reset values
`define RST_MASK 16'h0000
`define RST_RISE 16'hffff
`define RST_FALL 16'h0000
`define RST_SRE 8'h00
`define RST_PORT 3'h0
`define RST_PRIMARY 5'h05
// Address limits and types
`define PRIMARY_MAX 8'h1e
`define SEC_MIN 8'h01
`define SEC_MAX 8'h0f
`define TYPE_ALONE 2'h0
`define TYPE_DIRECT 2'h1
`define TYPE_LINKED 2'h2
// Keypad codes
`define KEY_SEP 4'ha
`define KEY_ENTER 4'hb
`define KEY_ADDR 4'hc
// Message bytes and error codes
`define CHAR_LF 8'h0a
`define CHAR_QUERY 8'h3f
`define ERR_NONE 16'h0000
`define ERR_QUERY_DEADLOCK 16'hfe52
// Trigger control bits
`define TRIG_ARM_BIT 0
`define TRIG_CONT_BIT 1
`define TRIG_FIRE_BIT 2
`endif

// ==== gpib_status_address_port.v ====
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpib_status_regs.vh"
module gpib_status_address_port #(
  parameter QUERY_DEPTH = 8
) (
  input wire clk, // 200 MHz clock
  input wire reset_n, // Synchronous reset
  input wire [3:0] addr, // Register index
  input wire [15:0] wdata, // Write data
  input wire we, // Write strobe
  input wire re, // Read strobe
  output reg [15:0] rdata, // Read data, cycle after re
  input wire cal_in, // Calibration mode pin
  input wire cv_in, // Constant-voltage pin
  input wire cc_in, // Constant-current pin
  input wire ov_in, // Overvoltage pin
  input wire oc_in, // Overcurrent pin
  input wire [4:0] direct_primary, // Primary of chain head
  input wire key_valid, // Keypad strobe
  input wire [3:0] key_code, // Keypad code
  input wire bus_valid, // Received byte strobe
  input wire [7:0] bus_byte, // Received byte
  input wire bus_eoi, // End-or-identify with byte
  input wire bus_trigger, // Trigger from controller
  output reg srq, // Service request
  output reg msg_end, // Message terminated pulse
  output reg apply_trigger, // Apply pending levels pulse
  output reg recall_state, // Recall location 0 pulse
  output reg addr_error, // Address error display
  output reg [4:0] primary_addr, // Active primary address
  output reg [3:0] secondary_addr, // Active secondary address
  output reg [1:0] addr_type, // Active address type
  output reg line1_out, // Control line one
  output reg line2_out, // Control line two
  output reg line3_out, // Control line three level
  output reg line3_oe_n, // Line three drive, low drives
  input wire line3_in // Control line three input
);

  function [7:0] accum;
    input [7:0] acc;
    input [3:0] d;
    reg [11:0] t;
    begin
      t = ({4'h0, acc} * 12'd10) + {8'h0, d};
      accum = (t > 12'h0ff) ? 8'hff : t[7:0];
    end
  endfunction

  // Pin inputs cross in through two stages
  reg [10:0] sync1_reg;
  reg [10:0] sync2_reg;
  always @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end else begin
      sync1_reg <= {direct_primary, line3_in, oc_in, ov_in, cc_in, cv_in, cal_in};
      sync2_reg <= sync1_reg;
    end
  end

  reg [15:0] run_cond_reg, run_event_reg, run_mask_reg, run_rise_reg, run_fall_reg;
  reg [15:0] flt_cond_reg, flt_event_reg, flt_mask_reg, flt_rise_reg, flt_fall_reg;
  reg [7:0] sre_reg;
  reg [2:0] port_reg;
  reg [15:0] error_reg;
  reg armed_reg, cont_reg;
  reg [3:0] qcount_reg;
  reg entering_reg, sep_reg, pdig_reg, sdig_reg, bad_reg;
  reg [7:0] pval_reg, sval_reg;
  reg [4:0] stored_primary_reg;

  wire wr_trig = we && (addr == `OFF_TRIG);
  wire trig_now = bus_trigger || (wr_trig && wdata[`TRIG_FIRE_BIT]);

  // Live conditions
  reg [15:0] run_live;
  reg [15:0] flt_live;
  always @* begin
    run_live = 16'h0000;
    flt_live = 16'h0000;
    // Calibration state bit
    // calibration at weight 1
    run_live[`RUN_CAL_BIT] = sync2_reg[0];
    run_live[`RUN_WTG_BIT] = armed_reg;
    run_live[`RUN_CV_BIT] = sync2_reg[1];
    run_live[`RUN_CC_BIT] = sync2_reg[2];
    flt_live[`FLT_OV_BIT] = sync2_reg[3];
    flt_live[`FLT_OC_BIT] = sync2_reg[4];
  end

  wire [15:0] run_new = ((run_live & ~run_cond_reg & run_rise_reg) |
                         (~run_live & run_cond_reg & run_fall_reg)) & `RUN_IMPL_MASK;
  wire [15:0] flt_new = ((flt_live & ~flt_cond_reg & flt_rise_reg) |
                         (~flt_live & flt_cond_reg & flt_fall_reg)) & `FLT_IMPL_MASK;

  wire rd_run_ev = re && (addr == `OFF_RUN_EVENT);
  wire rd_flt_ev = re && (addr == `OFF_FLT_EVENT);
  wire rd_err = re && (addr == `OFF_ERROR);
  wire [15:0] run_event_next = (rd_run_ev ? 16'h0000 : run_event_reg) | run_new;
  wire [15:0] flt_event_next = (rd_flt_ev ? 16'h0000 : flt_event_reg) | flt_new;

  wire run_sum = |(run_event_reg & run_mask_reg);
  wire flt_sum = |(flt_event_reg & flt_mask_reg);
  reg [7:0] stb;
  always @* begin
    stb = 8'h00;
    stb[`STB_RUN_BIT] = run_sum;
    stb[`STB_FLT_BIT] = flt_sum;
    stb[`STB_ERR_BIT] = (error_reg != `ERR_NONE);
  end
  wire rqs = |(stb & sre_reg & ~8'h40);

  always @(posedge clk) begin
    if (!reset_n) begin
      run_cond_reg <= 16'h0000;
      flt_cond_reg <= 16'h0000;
      run_event_reg <= 16'h0000;
      flt_event_reg <= 16'h0000;
      srq <= 1'b0;
    end else begin
      run_cond_reg <= run_live;
      flt_cond_reg <= flt_live;
      run_event_reg <= run_event_next;
      flt_event_reg <= flt_event_next;
      srq <= rqs;
    end
  end

  // Software registers; the address has no write path
  always @(posedge clk) begin
    if (!reset_n) begin
      run_mask_reg <= `RST_MASK;
      run_rise_reg <= `RST_RISE;
      run_fall_reg <= `RST_FALL;
      flt_mask_reg <= `RST_MASK;
      flt_rise_reg <= `RST_RISE;
      flt_fall_reg <= `RST_FALL;
      sre_reg <= `RST_SRE;
      port_reg <= `RST_PORT;
    end else if (we) begin
      case (addr)
        `OFF_RUN_MASK: run_mask_reg <= wdata;
        `OFF_RUN_RISE: run_rise_reg <= wdata;
        `OFF_RUN_FALL: run_fall_reg <= wdata;
        `OFF_FLT_MASK: flt_mask_reg <= wdata;
        `OFF_FLT_RISE: flt_rise_reg <= wdata;
        `OFF_FLT_FALL: flt_fall_reg <= wdata;
        `OFF_SRE: sre_reg <= wdata[7:0];
        `OFF_PORT: port_reg <= wdata[2:0];
        default: port_reg <= port_reg;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      line1_out <= 1'b0;
      line2_out <= 1'b0;
      line3_out <= 1'b0;
      line3_oe_n <= 1'b1;
    end else begin
      line1_out <= port_reg[0];
      line2_out <= port_reg[1];
      line3_out <= 1'b0;
      // Bit 2 set turns line three into an input
      line3_oe_n <= port_reg[2];
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
      cont_reg <= 1'b0;
      apply_trigger <= 1'b0;
    end else begin
      apply_trigger <= trig_now && armed_reg;
      if (wr_trig) begin
        cont_reg <= wdata[`TRIG_CONT_BIT];
      end
      if (wr_trig && (wdata[`TRIG_ARM_BIT] || wdata[`TRIG_CONT_BIT])) begin
        armed_reg <= 1'b1;
      end else if (trig_now && armed_reg) begin
        armed_reg <= cont_reg;
      end
    end
  end

  wire term = bus_valid && (bus_eoi || (bus_byte == `CHAR_LF));
  wire is_query = bus_valid && (bus_byte == `CHAR_QUERY);
  wire [4:0] qtotal = {1'b0, qcount_reg} + {4'h0, is_query};
  wire deadlock = term && (qtotal > QUERY_DEPTH[4:0]);

  always @(posedge clk) begin
    if (!reset_n) begin
      qcount_reg <= 4'h0;
      msg_end <= 1'b0;
      error_reg <= `ERR_NONE;
    end else begin
      msg_end <= term;
      if (term) begin
        qcount_reg <= 4'h0;
      end else if (is_query && qcount_reg != 4'hf) begin
        qcount_reg <= qcount_reg + 4'h1;
      end
      // Set wins over a read that clears
      if (deadlock) begin
        error_reg <= `ERR_QUERY_DEADLOCK;
      end else if (rd_err) begin
        error_reg <= `ERR_NONE;
      end
    end
  end

  // Address entry check
  reg [1:0] new_type;
  reg entry_ok;
  always @* begin
    new_type = `TYPE_ALONE;
    entry_ok = 1'b0;
    if (!sep_reg) begin
      new_type = `TYPE_ALONE;
      entry_ok = pdig_reg && (pval_reg <= `PRIMARY_MAX);
    end else if (pdig_reg) begin
      new_type = `TYPE_DIRECT;
      entry_ok = (pval_reg <= `PRIMARY_MAX) && (sval_reg == 8'h00);
    end else begin
      new_type = `TYPE_LINKED;
      entry_ok = sdig_reg && (sval_reg >= `SEC_MIN) && (sval_reg <= `SEC_MAX);
    end
    if (bad_reg) begin
      entry_ok = 1'b0;
    end
  end

  wire type_jump = ((addr_type == `TYPE_ALONE) && (new_type == `TYPE_DIRECT)) ||
                   ((addr_type == `TYPE_DIRECT) && (new_type != `TYPE_DIRECT)) ||
                   ((addr_type == `TYPE_LINKED) && (new_type == `TYPE_DIRECT));
  wire enter_now = key_valid && (key_code == `KEY_ENTER) && entering_reg;

  always @(posedge clk) begin
    if (!reset_n) begin
      entering_reg <= 1'b0;
      sep_reg <= 1'b0;
      pdig_reg <= 1'b0;
      sdig_reg <= 1'b0;
      bad_reg <= 1'b0;
      pval_reg <= 8'h00;
      sval_reg <= 8'h00;
    end else if (key_valid) begin
      if (key_code == `KEY_ADDR) begin
        entering_reg <= 1'b1;
        sep_reg <= 1'b0;
        pdig_reg <= 1'b0;
        sdig_reg <= 1'b0;
        bad_reg <= 1'b0;
        pval_reg <= 8'h00;
        sval_reg <= 8'h00;
      end else if (key_code == `KEY_ENTER) begin
        entering_reg <= 1'b0;
      end else if (entering_reg && key_code == `KEY_SEP) begin
        bad_reg <= bad_reg | sep_reg;
        sep_reg <= 1'b1;
      end else if (entering_reg && key_code < 4'ha) begin
        if (sep_reg) begin
          sval_reg <= accum(sval_reg, key_code);
          sdig_reg <= 1'b1;
        end else begin
          pval_reg <= accum(pval_reg, key_code);
          pdig_reg <= 1'b1;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      stored_primary_reg <= `RST_PRIMARY;
      primary_addr <= `RST_PRIMARY;
      secondary_addr <= 4'h0;
      addr_type <= `TYPE_ALONE;
      addr_error <= 1'b0;
      recall_state <= 1'b0;
    end else begin
      recall_state <= enter_now && entry_ok && type_jump;
      primary_addr <= (addr_type == `TYPE_LINKED) ? sync2_reg[10:6] : stored_primary_reg;
      if (key_valid && key_code == `KEY_ADDR) begin
        addr_error <= 1'b0;
      end
      if (enter_now) begin
        if (entry_ok) begin
          addr_type <= new_type;
          addr_error <= 1'b0;
          if (new_type == `TYPE_LINKED) begin
            secondary_addr <= sval_reg[3:0];
          end else begin
            stored_primary_reg <= pval_reg[4:0];
            secondary_addr <= 4'h0;
          end
        end else begin
          addr_error <= 1'b1;
        end
      end
    end
  end

  // Read mux; data valid only in the cycle after re
  reg [15:0] rd_mux;
  always @* begin
    case (addr)
      `OFF_RUN_COND: rd_mux = run_cond_reg;
      `OFF_RUN_EVENT: rd_mux = run_event_reg & run_mask_reg;
      `OFF_RUN_MASK: rd_mux = run_mask_reg;
      `OFF_RUN_RISE: rd_mux = run_rise_reg;
      `OFF_RUN_FALL: rd_mux = run_fall_reg;
      `OFF_FLT_COND: rd_mux = flt_cond_reg;
      `OFF_FLT_EVENT: rd_mux = flt_event_reg & flt_mask_reg;
      `OFF_FLT_MASK: rd_mux = flt_mask_reg;
      `OFF_FLT_RISE: rd_mux = flt_rise_reg;
      `OFF_FLT_FALL: rd_mux = flt_fall_reg;
      `OFF_SRE: rd_mux = {8'h00, sre_reg};
      `OFF_STB: rd_mux = {8'h00, stb | {1'b0, rqs, 6'h00}};
      `OFF_PORT: rd_mux = {12'h000, sync2_reg[5], port_reg};
      `OFF_ADDR: rd_mux = {3'h0, addr_error, addr_type, 1'b0, secondary_addr, primary_addr};
      `OFF_ERROR: rd_mux = error_reg;
      `OFF_TRIG: rd_mux = {14'h0000, cont_reg, armed_reg};
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= re ? rd_mux : 16'h0000;
    end
  end

endmodule // gpib_status_address_port
`default_nettype wire

// ==== gpib_status_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpib_status_props #(
  parameter QUERY_DEPTH = 8
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic we, // Write
  input wire logic re, // Read
  input wire logic [3:0] addr, // Index
  input wire logic [15:0] rdata, // Read data
  input wire logic key_valid, // Key strobe
  input wire logic bus_valid, // Byte strobe
  input wire logic [7:0] bus_byte, // Byte
  input wire logic bus_eoi, // End flag
  input wire logic bus_trigger, // Trigger
  input wire logic msg_end, // Message end
  input wire logic apply_trigger, // Apply
  input wire logic recall_state, // Recall
  input wire logic [4:0] primary_addr, // Primary
  input wire logic [3:0] secondary_addr, // Secondary
  input wire logic [1:0] addr_type, // Type
  input wire logic line3_out, // Line three
  input wire logic line3_oe_n // Drive, low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence term_s;
    bus_valid && (bus_eoi || bus_byte == 8'h0a);
  endsequence
  msg_end_term_a: assert property (term_s |=> msg_end)
    else $error("terminator without message end");
  apply_cause_a: assert property (apply_trigger |->
    $past(bus_trigger) || $past(we && addr == 4'hf))
    else $error("apply without trigger");
  addr_frozen_a: assert property (we && !key_valid |=> $stable(addr_type))
    else $error("address type changed by bus");
  recall_need_a: assert property ($past(reset_n) && addr_type != $past(addr_type) &&
    (addr_type | $past(addr_type)) != 2'h2 |-> recall_state)
    else $error("type change without recall");
  sec_direct_a: assert property (addr_type == 2'h1 |-> secondary_addr == 4'h0)
    else $error("direct unit secondary not zero");
  sec_linked_a: assert property (addr_type == 2'h2 |-> secondary_addr != 4'h0)
    else $error("linked unit secondary zero");
  prim_range_a: assert property (addr_type != 2'h2 |-> primary_addr <= 5'h1e)
    else $error("primary above 30");
  line3_level_a: assert property (!line3_oe_n |-> !line3_out)
    else $error("line three driven high");
  addr_read_a: assert property (re && addr == 4'hd |=>
    rdata[4:0] == $past(primary_addr) && rdata[11:10] == $past(addr_type))
    else $error("address readback wrong");
endmodule // gpib_status_props
bind gpib_status_address_port gpib_status_props #(.QUERY_DEPTH(QUERY_DEPTH)) props_inst (
  .clk(clk), .reset_n(reset_n), .we(we), .re(re), .addr(addr), .rdata(rdata),
  .key_valid(key_valid), .bus_valid(bus_valid), .bus_byte(bus_byte), .bus_eoi(bus_eoi),
  .bus_trigger(bus_trigger), .msg_end(msg_end), .apply_trigger(apply_trigger),
  .recall_state(recall_state), .primary_addr(primary_addr), .secondary_addr(secondary_addr),
  .addr_type(addr_type), .line3_out(line3_out), .line3_oe_n(line3_oe_n));
`default_nettype wire

// ==== bus_controller_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model (
  input wire logic clk, // Clock
  output var logic bus_valid, // Byte strobe
  output var logic [7:0] bus_byte, // Byte
  output var logic bus_eoi, // End flag
  output var logic bus_trigger // Trigger
);
  initial begin
    bus_valid = 1'b0;
    bus_byte = 8'h55;
    bus_eoi = 1'b0;
    bus_trigger = 1'b0;
  end
  task automatic put(input logic [7:0] b, input logic eoi);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_byte <= b;
    bus_eoi <= eoi;
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_eoi <= 1'b0;
    // Released lines must not look like the last byte
    bus_byte <= ~b;
  endtask
  function automatic logic [7:0] sec_code(input logic [3:0] sec);
    return 8'h60 + {4'h0, sec};
  endfunction
  task automatic send_queries(input int n, input logic use_eoi);
    for (int i = 0; i < n; i++) begin
      put(8'h3f, use_eoi && (i == n - 1));
    end
    if (!use_eoi) begin
      put(8'h0a, 1'b0);
    end
  endtask
  task automatic fire();
    @(posedge clk);
    bus_trigger <= 1'b1;
    @(posedge clk);
    bus_trigger <= 1'b0;
  endtask
endmodule // bus_controller_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int QD = 4;
  logic clk = 1'b0, reset_n = 1'b0, we = 1'b0, re = 1'b0, key_valid = 1'b0;
  logic [3:0] addr = 4'h0, key_code = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic cal_in = 1'b0, cv_in = 1'b1, cc_in = 1'b0, ov_in = 1'b0, oc_in = 1'b0;
  logic line3_ext = 1'b0, line3_in, bus_valid, bus_eoi, bus_trigger, srq, msg_end;
  logic apply_trigger, recall_state, addr_error, line1_out, line2_out, line3_out, line3_oe_n;
  logic [4:0] direct_primary = 5'h06, primary_addr;
  logic [7:0] bus_byte;
  logic [3:0] secondary_addr;
  logic [1:0] addr_type;
  int bad_count = 0, total_checks = 0, rec_cnt = 0, msg_cnt = 0, app_cnt = 0;
  // Line three sees its own drive when enabled
  assign line3_in = line3_oe_n ? line3_ext : line3_out;
  initial begin
    forever #2.5 clk = ~clk;
  end
  gpib_status_address_port #(.QUERY_DEPTH(QD)) gpib_status_address_port_inst (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .cal_in(cal_in), .cv_in(cv_in), .cc_in(cc_in), .ov_in(ov_in),
    .oc_in(oc_in), .direct_primary(direct_primary), .key_valid(key_valid),
    .key_code(key_code), .bus_valid(bus_valid), .bus_byte(bus_byte), .bus_eoi(bus_eoi),
    .bus_trigger(bus_trigger), .srq(srq), .msg_end(msg_end), .apply_trigger(apply_trigger),
    .recall_state(recall_state), .addr_error(addr_error), .primary_addr(primary_addr),
    .secondary_addr(secondary_addr), .addr_type(addr_type), .line1_out(line1_out),
    .line2_out(line2_out), .line3_out(line3_out), .line3_oe_n(line3_oe_n),
    .line3_in(line3_in));
  bus_controller_model bus_controller_model_inst (.clk(clk), .bus_valid(bus_valid),
    .bus_byte(bus_byte), .bus_eoi(bus_eoi), .bus_trigger(bus_trigger));
  always @(posedge clk) begin
    if (recall_state === 1'b1)
      rec_cnt <= rec_cnt + 1;
    if (msg_end === 1'b1)
      msg_cnt <= msg_cnt + 1;
    if (apply_trigger === 1'b1)
      app_cnt <= app_cnt + 1;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic key(input logic [3:0] k);
    @(posedge clk);
    key_valid <= 1'b1;
    key_code <= k;
    @(posedge clk);
    key_valid <= 1'b0;
  endtask
  task automatic entry(input logic [15:0] ks, input int n, input logic [15:0] exp, input int rec);
    int r0;
    logic [15:0] v;
    r0 = rec_cnt;
    key(4'hc);
    for (int i = n - 1; i >= 0; i--) key(ks[4*i +: 4]);
    key(4'hb);
    idle(4);
    chk("addr_pins", {3'h0, addr_error, addr_type, 1'b0, secondary_addr, primary_addr}, exp);
    rd(4'hd, v);
    chk("addr_reg", v, exp);
    chk("recall", 16'(rec_cnt - r0), 16'(rec));
  endtask
  task automatic s_reset();
    logic [15:0] v;
    rd(4'hd, v);
    chk("addr_reset", v, 16'h0005);
    wr(4'hd, 16'h001f);
    rd(4'hd, v);
    chk("addr_locked", v, 16'h0005);
  endtask
  task automatic s_run();
    logic [15:0] v;
    wr(4'h2, 16'h0500);
    wr(4'h3, 16'h0400);
    wr(4'ha, 16'h0080);
    rd(4'h1, v);
    cc_in <= 1'b1;
    cv_in <= 1'b0;
    idle(8);
    chk("srq_run", {15'h0, srq}, 16'h0001);
    rd(4'hb, v);
    chk("stb_run", {15'h0, v[7]}, 16'h0001);
    rd(4'h1, v);
    chk("run_event", v, 16'h0400);
    rd(4'h1, v);
    chk("run_cleared", v, 16'h0000);
    rd(4'h0, v);
    chk("run_cond", v, 16'h0400);
    idle(2);
    chk("srq_drop", {15'h0, srq}, 16'h0000);
  endtask
  task automatic s_mask();
    logic [15:0] v;
    wr(4'h3, 16'hffff);
    wr(4'h4, 16'h0001);
    cal_in <= 1'b1;
    cc_in <= 1'b0;
    cv_in <= 1'b1;
    idle(8);
    rd(4'h1, v);
    chk("mask_1280", v, 16'h0100);
    wr(4'h2, 16'hffff);
    rd(4'h1, v);
    cal_in <= 1'b0;
    idle(8);
    rd(4'h1, v);
    chk("cal_leave", v, 16'h0001);
    cal_in <= 1'b1;
    cc_in <= 1'b1;
    cv_in <= 1'b0;
    idle(8);
    rd(4'h1, v);
    chk("all_bits", v, 16'h0401);
    rd(4'h0, v);
    chk("cond_live", v, 16'h0401);
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    cal_in <= 1'b0;
    cc_in <= 1'b0;
    cv_in <= 1'b1;
    idle(8);
    rd(4'h1, v);
  endtask
  task automatic s_fault();
    logic [15:0] v;
    wr(4'h7, 16'h0003);
    wr(4'h8, 16'h0003);
    wr(4'ha, 16'h0088);
    ov_in <= 1'b1;
    idle(8);
    chk("srq_fault", {15'h0, srq}, 16'h0001);
    rd(4'hb, v);
    chk("stb_fault", {15'h0, v[3]}, 16'h0001);
    rd(4'h6, v);
    chk("fault_ov", v, 16'h0001);
    oc_in <= 1'b1;
    idle(8);
    rd(4'h6, v);
    chk("fault_oc", v, 16'h0002);
    ov_in <= 1'b0;
    oc_in <= 1'b0;
    idle(2);
    chk("srq_clear", {15'h0, srq}, 16'h0000);
  endtask
  task automatic s_port();
    logic [15:0] v;
    wr(4'hc, 16'h0003);
    rd(4'hc, v);
    chk("port_rd", v, 16'h0003);
    chk("port_out", {13'h0, line1_out, line2_out, line3_oe_n}, 16'h0006);
    line3_ext <= 1'b1;
    wr(4'hc, 16'h0004);
    idle(3);
    rd(4'hc, v);
    chk("port_in", v, 16'h000c);
    chk("port_low", {13'h0, line1_out, line2_out, line3_oe_n}, 16'h0001);
  endtask
  task automatic s_addr();
    entry(16'h0006, 1, 16'h0006, 0);
    entry(16'h006a, 2, 16'h0406, 1);
    entry(16'h0a12, 3, 16'h0986, 1);
    entry(16'ha010, 4, 16'h0946, 0);
    entry(16'h0031, 2, 16'h1946, 0);
    entry(16'h0a16, 3, 16'h1946, 0);
    entry(16'h0030, 2, 16'h001e, 0);
    entry(16'h07a0, 3, 16'h0407, 1);
    entry(16'h00a3, 2, 16'h0866, 1);
    entry(16'h005a, 2, 16'h0405, 1);
  endtask
  task automatic s_msg();
    logic [15:0] v;
    int m0;
    m0 = msg_cnt;
    bus_controller_model_inst.put(bus_controller_model_inst.sec_code(4'hc), 1'b0);
    bus_controller_model_inst.send_queries(QD, 1'b0);
    rd(4'he, v);
    chk("err_none", v, 16'h0000);
    bus_controller_model_inst.send_queries(QD + 1, 1'b1);
    rd(4'hb, v);
    chk("stb_err", {15'h0, v[2]}, 16'h0001);
    rd(4'he, v);
    chk("err_code", v, 16'hfe52);
    chk("msg_ends", 16'(msg_cnt - m0), 16'h0002);
  endtask
  task automatic s_trigger();
    int a0;
    a0 = app_cnt;
    bus_controller_model_inst.fire();
    wr(4'hf, 16'h0001);
    bus_controller_model_inst.fire();
    bus_controller_model_inst.fire();
    idle(3);
    chk("apply_once", 16'(app_cnt - a0), 16'h0001);
    wr(4'hf, 16'h0002);
    bus_controller_model_inst.fire();
    bus_controller_model_inst.fire();
    idle(3);
    chk("apply_cont", 16'(app_cnt - a0), 16'h0003);
    wr(4'hf, 16'h0004);
    idle(3);
    chk("apply_write", 16'(app_cnt - a0), 16'h0004);
  endtask
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Run needs about 340 cycles; allow about thirty times that
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    idle(3);
    s_reset();
    s_run();
    s_mask();
    s_fault();
    s_port();
    s_addr();
    s_msg();
    s_trigger();
    complete_run();
  end
endmodule // testbench
`default_nettype wire
